// file: mshrp_pkg.sv
// Constants, field positions and carrier types of the serial HID register port.
// Assumes a single 100 MHz clock domain in every module that imports it.
package mshrp_pkg;

   // ************************************************************
   // Bus address and register offsets
   // ************************************************************
   localparam logic [6:0] SLAVE_ADDR = 7'h38;    // Fixed 7-bit slave address.
   localparam logic [3:0] OFS_IN0 = 4'h0;        // Input report byte 0.
   localparam logic [3:0] OFS_IN3 = 4'h3;        // Input report byte 3.
   localparam logic [3:0] OFS_OUT0 = 4'h4;       // Output report byte 0.
   localparam logic [3:0] OFS_OUT1 = 4'h5;       // Output report byte 1.
   localparam logic [3:0] OFS_OUT2 = 4'h6;       // Output report byte 2.
   localparam logic [3:0] OFS_OUT3 = 4'h7;       // Output report byte 3.
   localparam logic [3:0] OFS_CLKSEL = 4'h8;     // Controller clock select.
   localparam logic [3:0] OFS_ROMLO = 4'h9;      // Rom word low byte.
   localparam logic [3:0] OFS_ROMHI = 4'ha;      // Rom word high byte.
   localparam logic [3:0] OFS_ROMCTL = 4'hb;     // Rom access control.

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int IN0_MODE_HI = 7;               // Mode field top bit of input byte 0.
   localparam int IN0_MODE_LO = 6;               // Mode field low bit.
   localparam logic [1:0] MODE_MIRROR = 2'h2;    // Mode value that mirrors into indirect registers.
   localparam logic [7:0] BTN_MASK = 8'h0f;      // Button bits of input byte 0.
   localparam logic [7:0] CLKSEL_MASK = 8'h30;   // Writable clock select bits 5:4.
   localparam int ROM_GO_BIT = 7;                // Start and pending bit.
   localparam int ROM_DIR_BIT = 6;               // Direction bit, 1 writes.
   localparam logic [7:0] RESET_BYTE = 8'h00;    // Reset value of every register.
   localparam logic [7:0] OUT0_MAPPED = 8'hc0; // Output byte 0 image while mapping is on.

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed
   {
      logic start; // START or repeated START seen.
      logic stop; // STOP seen.
      logic rise; // Clock rising edge.
      logic fall; // Clock falling edge.
      logic sda; // Synchronised data level.
   } mshrp_line_t;

   typedef struct packed
   {
      logic valid; // One-cycle request pulse.
      logic write; // 1 writes, 0 reads.
      logic [3:0] addr; // Register index.
      logic [7:0] data; // Write data.
   } mshrp_req_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100
   } mshrp_state_t;

endpackage

// file: mshrp_line_sync.sv
// Synchroniser and condition detector for the two-wire pins.
// Assumes both pins are asynchronous to ref_clk.
`timescale 1ns/1ps
module mshrp_line_sync
   import mshrp_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Raw pins.
   input wire logic scl_in,
   input wire logic sda_in,
   // Decoded line events.
   output mshrp_line_t line
);

   // ************************************************************
   // Two-stage synchronisers and one history stage
   // ************************************************************
   logic [1:0] scl_meta, next_scl_meta;  // First and second stages of clock.
   logic [1:0] sda_meta, next_sda_meta;  // First and second stages of data.
   logic scl_d, sda_d;                   // Previous synchronised levels.
   mshrp_line_t next_line;               // Next decoded events.

   // Computes the next synchroniser state and the events from stage two and the history stage.
   always_comb
   begin
      next_scl_meta = {scl_meta[0], scl_in};
      next_sda_meta = {sda_meta[0], sda_in};
      next_line.sda = sda_meta[1];
      next_line.rise = scl_meta[1] & ~scl_d;
      next_line.fall = ~scl_meta[1] & scl_d;
      next_line.start = scl_meta[1] & scl_d & sda_d & ~sda_meta[1]; // R3 R4
      next_line.stop = scl_meta[1] & scl_d & ~sda_d & sda_meta[1];  // R3 R4
   end

   // Registers the synchroniser, history and events; idle bus reads high.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         scl_meta <= 2'h3;
         sda_meta <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         line <= '0;
      end
      else
      begin
         scl_meta <= next_scl_meta;
         sda_meta <= next_sda_meta;
         scl_d <= scl_meta[1];
         sda_d <= sda_meta[1];
         line <= next_line;
      end
   end

endmodule

// file: mshrp_port.sv
// Two-wire slave register port with HID report and rom access registers.
// Assumes the master drives the clock and the wire pulls data high when released.
// Behaviour
// R1: Answers only slave address 0111000 plus direction.
// R2: Slave only, oversampled well beyond 400 kbps.
// R3: Transactions open at START, end STOP/repeated START.
// R4: Data sampled while clock high; edges detect conditions.
// R5: Acknowledge bit follows every eight data bits.
// R6: Master ends with STOP/START after negative acknowledge.
// R7: Clock input only; data driven open-drain.
// R8: Device always acknowledges its address byte.
// R9: First write byte sets pointer, then auto-increment.
// R10: Reads return current pointer, then increment.
// R11: Master reads with pointer write then read.
// R12: Master writes ideally start at pointer zero.
// R13: Master write sends four-byte report upstream.
// R14: Button change or new data resends report.
// R15: Master spaces writes beyond one polling interval.
// R16: Set Output Report loads output report bytes.
// R17: Input byte 0 bits 3:0 show buttons only.
// R18: Output bytes 1-3 read-only; mapped when bit 7.
// R19: Clock select bits 5:4 choose controller clock.
// R20: Start bit self-clears, reads pending, zero ignored.
// R21: Bit 6 direction, bits 5:0 rom word address.
// R22: Two data bytes hold rom word.
// R23: Interrupt on output report update, cleared by read.
// R24: Interrupt on rom completion, cleared by read.
// R25: Mode 2 mirrors input bytes into indirect registers.
// R26: Other addresses ignored, data released until START.
`timescale 1ns/1ps
module mshrp_port
   import mshrp_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Two-wire pins; the clock is an input only.
   input wire logic serial_clk_in,
   input wire logic serial_data_io_in,
   output logic serial_data_io_out,
   output logic serial_data_io_oe,
   // Controller interrupt.
   output logic controller_irq_out,
   // Buttons, levels from the pins.
   input wire logic [3:0] button_in,
   // Upstream report to the USB side.
   output logic report_send,
   output logic [31:0] report_data,
   // Set Output Report from the USB side.
   input wire logic host_out_load,
   input wire logic [31:0] host_out_data,
   // Rom engine handshake.
   output logic rom_start,
   output logic rom_write,
   output logic [5:0] rom_addr,
   output logic [15:0] rom_wdata,
   input wire logic rom_done,
   input wire logic [15:0] rom_rdata,
   // Selected controller clock code.
   output logic [1:0] controller_clock_code
);

   // ************************************************************
   // Declarations
   // ************************************************************
   mshrp_line_t line;                         // Decoded pin events.
   mshrp_state_t state, next_state;           // Bit engine state.
   logic [3:0] bit_cnt, next_bit_cnt;         // Bits done in the byte.
   logic [7:0] shreg, next_shreg;             // Shift register.
   logic first, next_first;                   // Address byte pending.
   logic ptr_phase, next_ptr_phase;           // Next write byte is the pointer.
   logic [3:0] ptr, next_ptr;                 // Register pointer.
   logic drive_low, next_drive_low;           // Holds data low.
   logic master_ack;                          // Sampled master acknowledge.
   logic [7:0] in_rpt [4];                    // Input report bytes.
   logic [7:0] next_in_rpt [4];
   logic [7:0] out_rpt [4];                   // Host programmed output bytes.
   logic [7:0] next_out_rpt [4];
   logic [7:0] controller_clock_select, next_controller_clock_select;
   logic [7:0] rom_word_low, next_rom_word_low;
   logic [7:0] rom_word_high, next_rom_word_high;
   logic [7:0] rom_access_control, next_rom_access_control;
   logic pending, next_pending;               // Rom access in flight.
   logic irq, next_irq;                       // Interrupt level.
   logic [3:0] out_read, next_out_read;       // Output bytes read since raise.
   logic [3:0] btn_s1, btn_s2, btn_d;         // Button synchroniser and history.
   logic next_send;                           // Report send pulse.
   logic [7:0] rd_byte;                       // Byte at the pointer.
   logic wr_en;                               // Register write strobe.
   logic rd_en;                               // Register read strobe.
   logic [7:0] wr_data;                       // Register write data.
   logic map_on;                              // Output mapping active.

   // Pin synchroniser and condition detector.
   mshrp_line_sync u_sync // R2
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .scl_in(serial_clk_in),
      .sda_in(serial_data_io_in),
      .line(line)
   );

   // ************************************************************
   // Register read view
   // ************************************************************
   assign map_on = in_rpt[0][IN0_MODE_HI];
   assign master_ack = ~line.sda;

   // Selects the byte at the pointer, with mapping of the output bytes.
   always_comb
   begin
      unique case (ptr)
         OFS_IN0: rd_byte = in_rpt[0];
         4'h1: rd_byte = in_rpt[1];
         4'h2: rd_byte = in_rpt[2];
         OFS_IN3: rd_byte = in_rpt[3];
         OFS_OUT0: rd_byte = map_on ? (OUT0_MAPPED | (controller_clock_select & CLKSEL_MASK)) : out_rpt[0];
         OFS_OUT1: rd_byte = map_on ? rom_word_low : out_rpt[1];       // R18
         OFS_OUT2: rd_byte = map_on ? rom_word_high : out_rpt[2];      // R18
         OFS_OUT3: rd_byte = map_on ? {pending, rom_access_control[6:0]} : out_rpt[3]; // R18
         OFS_CLKSEL: rd_byte = controller_clock_select;
         OFS_ROMLO: rd_byte = rom_word_low;
         OFS_ROMHI: rd_byte = rom_word_high;
         OFS_ROMCTL: rd_byte = {pending, rom_access_control[6:0]};     // R20
         default: rd_byte = RESET_BYTE;
      endcase
   end

   // ************************************************************
   // Bit engine
   // ************************************************************
   // Walks address, data and acknowledge bits on clock edges.
   always_comb
   begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_first = first;
      next_ptr_phase = ptr_phase;
      next_ptr = ptr;
      next_drive_low = drive_low;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_data = shreg;
      if (line.start)
      begin
         // Any START, repeated or not, restarts address reception.
         next_state = ST_RX; // R3
         next_bit_cnt = 4'h0;
         next_first = 1'b1;
         next_drive_low = 1'b0;
      end
      else if (line.stop)
      begin
         next_state = ST_IDLE; // R3
         next_drive_low = 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               next_drive_low = 1'b0; // R26
            end
            ST_RX:
            begin
               if (line.rise)
               begin
                  next_shreg = {shreg[6:0], line.sda}; // R4
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (line.fall && bit_cnt == 4'h8)
               begin
                  if (first && shreg[7:1] != SLAVE_ADDR)
                  begin
                     next_state = ST_IDLE; // R1 R26
                  end
                  else
                  begin
                     next_state = ST_RX_ACK;
                     next_drive_low = 1'b1; // R5 R8
                  end
               end
            end
            ST_RX_ACK:
            begin
               if (line.fall)
               begin
                  next_bit_cnt = 4'h0;
                  if (first)
                  begin
                     next_first = 1'b0;
                     next_ptr_phase = ~shreg[0];
                     if (shreg[0])
                     begin
                        // Read: present the byte at the pointer.
                        next_state = ST_TX;
                        next_shreg = rd_byte; // R10
                        next_drive_low = ~rd_byte[7];
                        rd_en = 1'b1;
                     end
                     else
                     begin
                        next_state = ST_RX;
                        next_drive_low = 1'b0;
                     end
                  end
                  else
                  begin
                     next_state = ST_RX;
                     next_drive_low = 1'b0;
                     if (ptr_phase)
                     begin
                        next_ptr = shreg[3:0]; // R9
                        next_ptr_phase = 1'b0;
                     end
                     else
                     begin
                        wr_en = 1'b1; // R9
                        next_ptr = ptr + 4'h1;
                     end
                  end
               end
            end
            ST_TX:
            begin
               if (line.fall)
               begin
                  next_bit_cnt = bit_cnt + 4'h1;
                  if (bit_cnt == 4'h7)
                  begin
                     next_state = ST_TX_ACK;
                     next_drive_low = 1'b0; // R5
                     next_ptr = ptr + 4'h1; // R10
                  end
                  else
                  begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_drive_low = ~shreg[6]; // R7
                  end
               end
            end
            ST_TX_ACK:
            begin
               if (line.rise)
               begin
                  next_first = master_ack;
               end
               else if (line.fall)
               begin
                  next_bit_cnt = 4'h0;
                  if (first)
                  begin
                     next_state = ST_TX;
                     next_shreg = rd_byte; // R10
                     next_drive_low = ~rd_byte[7];
                     rd_en = 1'b1;
                     next_first = 1'b0;
                  end
                  else
                  begin
                     next_state = ST_IDLE; // R6
                  end
               end
            end
            default:
            begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Register file and events
   // ************************************************************
   // Applies master writes, host loads, rom completion and interrupt.
   always_comb
   begin
      next_in_rpt = in_rpt;
      next_out_rpt = out_rpt;
      next_controller_clock_select = controller_clock_select;
      next_rom_word_low = rom_word_low;
      next_rom_word_high = rom_word_high;
      next_rom_access_control = rom_access_control;
      next_pending = pending;
      next_irq = irq;
      next_out_read = out_read;
      next_send = 1'b0;
      next_in_rpt[0] = (in_rpt[0] & ~BTN_MASK) | {4'h0, btn_s2}; // R17
      if (btn_s2 != btn_d)
      begin
         next_send = 1'b1; // R14
      end
      if (wr_en)
      begin
         next_send = 1'b1; // R13 R14
         unique case (ptr)
            OFS_IN0: next_in_rpt[0] = (wr_data & ~BTN_MASK) | {4'h0, btn_s2}; // R17
            4'h1: next_in_rpt[1] = wr_data;
            4'h2: next_in_rpt[2] = wr_data;
            OFS_IN3: next_in_rpt[3] = wr_data;
            OFS_CLKSEL: next_controller_clock_select = wr_data & CLKSEL_MASK; // R19
            OFS_ROMLO: next_rom_word_low = wr_data; // R22
            OFS_ROMHI: next_rom_word_high = wr_data; // R22
            OFS_ROMCTL: next_rom_access_control = wr_data; // R20 R21
            default: next_send = 1'b1;
         endcase
         if (next_in_rpt[0][IN0_MODE_HI:IN0_MODE_LO] == MODE_MIRROR)
         begin
            unique case (ptr)
               OFS_IN0: next_controller_clock_select = wr_data & CLKSEL_MASK; // R25
               4'h1: next_rom_word_low = wr_data;            // R25
               4'h2: next_rom_word_high = wr_data;           // R25
               OFS_IN3: next_rom_access_control = wr_data;   // R25
               default: next_send = 1'b1;
            endcase
         end
      end
      if (host_out_load)
      begin
         for (int i = 0; i < 4; i++)
         begin
            next_out_rpt[i] = host_out_data[8*i +: 8]; // R16
         end
      end
      // Completion first, then the self-clearing start, so a start wins a tie.
      if (rom_done && pending)
      begin
         next_pending = 1'b0;
         if (!rom_access_control[ROM_DIR_BIT])
         begin
            {next_rom_word_high, next_rom_word_low} = rom_rdata; // R22
         end
      end
      if (rom_access_control[ROM_GO_BIT])
      begin
         next_rom_access_control[ROM_GO_BIT] = 1'b0; // R20
         next_pending = 1'b1;
      end
      // Read tracking: all four output bytes read clears the interrupt.
      if (rd_en && ptr >= OFS_OUT0 && ptr <= OFS_OUT3)
      begin
         next_out_read[ptr[1:0]] = 1'b1;
      end
      if (out_read == 4'hf)
      begin
         next_irq = 1'b0; // R23 R24
         next_out_read = 4'h0;
      end
      // Raising events win over the read clear.
      if (host_out_load || (rom_done && pending))
      begin
         next_irq = 1'b1; // R23 R24
         next_out_read = 4'h0;
      end
   end

   // Registers engine and register file state.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         first <= 1'b0;
         ptr_phase <= 1'b0;
         ptr <= 4'h0;
         drive_low <= 1'b0;
         in_rpt <= '{default: 8'h00};
         out_rpt <= '{default: 8'h00};
         controller_clock_select <= 8'h00;
         rom_word_low <= 8'h00;
         rom_word_high <= 8'h00;
         rom_access_control <= 8'h00;
         pending <= 1'b0;
         irq <= 1'b0;
         out_read <= 4'h0;
         btn_s1 <= 4'h0;
         btn_s2 <= 4'h0;
         btn_d <= 4'h0;
         report_send <= 1'b0;
      end
      else
      begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         first <= next_first;
         ptr_phase <= next_ptr_phase;
         ptr <= next_ptr;
         drive_low <= next_drive_low;
         in_rpt <= next_in_rpt;
         out_rpt <= next_out_rpt;
         controller_clock_select <= next_controller_clock_select;
         rom_word_low <= next_rom_word_low;
         rom_word_high <= next_rom_word_high;
         rom_access_control <= next_rom_access_control;
         pending <= next_pending;
         irq <= next_irq;
         out_read <= next_out_read;
         btn_s1 <= button_in;
         btn_s2 <= btn_s1;
         btn_d <= btn_s2;
         report_send <= next_send;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign serial_data_io_out = 1'b0;                     // R7
   assign serial_data_io_oe = drive_low;                 // R7
   assign controller_irq_out = irq;
   assign report_data = {in_rpt[3], in_rpt[2], in_rpt[1], in_rpt[0]}; // R13
   assign rom_start = rom_access_control[ROM_GO_BIT];
   assign rom_write = rom_access_control[ROM_DIR_BIT];  // R21
   assign rom_addr = rom_access_control[5:0];           // R21
   assign rom_wdata = {rom_word_high, rom_word_low};
   assign controller_clock_code = controller_clock_select[5:4]; // R19

endmodule

// file: mshrp_port_assertions.sv
// Concurrent checks on the ports of the serial HID register port.
// Assumes one ref_clk domain; it is bound to every instance of the port.
`timescale 1ns/1ps
module mshrp_port_assertions
   import mshrp_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Watched ports.
   input wire logic serial_clk_in,
   input wire logic serial_data_io_out,
   input wire logic serial_data_io_oe,
   input wire logic controller_irq_out,
   input wire logic report_send,
   input wire logic host_out_load,
   input wire logic rom_start,
   input wire logic rom_done
);
   // All checks share the port clock; all but reset_idle_a are disabled by its reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   irq_on_load_a: assert property (host_out_load |=> controller_irq_out) else $error("irq missed a load");
   irq_on_rom_a: assert property (rom_done |=> controller_irq_out) else $error("irq missed rom end");
   irq_cause_a: assert property ($rose(controller_irq_out) |-> $past(host_out_load) || $past(rom_done))
      else $error("irq without cause");
   go_pulse_a: assert property (rom_start |=> !rom_start) else $error("rom start held");
   send_pulse_a: assert property (report_send |=> !report_send) else $error("report send held");
   open_drain_a: assert property (!serial_data_io_out) else $error("data driven high");
   data_change_a: assert property ($changed(serial_data_io_oe) |-> !serial_clk_in) else $error("data moved");
   reset_idle_a: assert property (@(posedge ref_clk) disable iff (1'b0) !rst_n |=> !serial_data_io_oe
      && !controller_irq_out && !report_send) else $error("busy in reset");
   // Main scenarios.
   load_c: cover property (host_out_load);
   rom_c: cover property (rom_start);
   send_c: cover property (report_send);
endmodule
bind mshrp_port mshrp_port_assertions u_chk (.ref_clk, .rst_n, .serial_clk_in, .serial_data_io_out,
   .serial_data_io_oe, .controller_irq_out, .report_send, .host_out_load, .rom_start, .rom_done);

// file: mshrp_master_model.sv
// Two-wire master standing in for the external controller.
// Assumes a pull-up on the data wire; steps are 40 ns, a bit is 160 ns.
`timescale 1ns/1ps
module mshrp_master_model
(
   // Wire side.
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // The clock idles high and stands still between frames.
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // One bit: data set while the clock is low, sampled while high.
   task automatic clk_bit(input logic drive, output logic seen);
      sda_low = ~drive;
      #40 scl = 1'b1;
      #40 seen = sda;
      #40 scl = 0;
      #40;
   endtask
   // Eight bits then the acknowledge slot; last is what the master drives there.
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
      clk_bit(last, a);
      ack = ~a;
   endtask
   // START or repeated START.
   task automatic start();
      sda_low = 1'b0;
      #40 scl = 1'b1;
      #40 sda_low = 1'b1;
      #40 scl = 1'b0;
      #40;
   endtask
   // STOP, leaving both lines released.
   task automatic stop();
      sda_low = 1'b1;
      #40 scl = 1'b1;
      #40 sda_low = 1'b0;
      #40;
   endtask
endmodule

// file: tb.sv
// Self-checking bench of the serial HID register port.
// Assumes the master model and a pull-up on the data wire.
`timescale 1ns/1ps
module tb
   import mshrp_pkg::*;
;
   `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic host_load = 1'b0;
   logic rom_done = 1'b0;
   logic [15:0] rom_rdata = 16'h0000;
   logic [3:0] btn = 4'h5;
   logic [31:0] host_data = 32'h00000000;
   logic scl, sda_low, oe, irq, send, rom_start, rom_write, ack;
   logic [31:0] rpt;
   logic [15:0] rom_wdata;
   logic [5:0] rom_addr;
   logic [1:0] clk_code;
   logic [7:0] junk;
   logic [7:0] rd [4];
   int fail_count = 0;
   int checks_done = 0;
   int sends = 0;
   int starts = 0;
   wire sda = ~(oe | sda_low);
   always #5 ref_clk = ~ref_clk;
   mshrp_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk_in(scl), .serial_data_io_in(sda),
      .serial_data_io_out(), .serial_data_io_oe(oe), .controller_irq_out(irq), .button_in(btn),
      .report_send(send), .report_data(rpt), .host_out_load(host_load), .host_out_data(host_data),
      .rom_start(rom_start), .rom_write(rom_write), .rom_addr(rom_addr), .rom_wdata(rom_wdata),
      .rom_done(rom_done), .rom_rdata(rom_rdata), .controller_clock_code(clk_code));
   mshrp_master_model M (.scl(scl), .sda_low(sda_low), .sda(sda));
   // Pulse counters.
   always @(posedge ref_clk)
   begin
      sends += send;
      starts += rom_start;
   end
   // Pointer then n data bytes.
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d [4], input int n);
      M.start();
      M.xfer({SLAVE_ADDR, 1'b0}, 1'b1, junk, ack);
      `CHK("addr ack", 1'b1, ack)
      M.xfer(ptr, 1'b1, junk, ack);
      for (int i = 0; i < n; i++) M.xfer(d[i], 1'b1, junk, ack);
      M.stop();
   endtask
   // Pointer write, then n bytes read, the last refused.
   task automatic rd_regs(input logic [7:0] ptr, input int n);
      wr(ptr, rd, 0);
      M.start();
      M.xfer({SLAVE_ADDR, 1'b1}, 1'b1, junk, ack);
      for (int i = 0; i < n; i++) M.xfer(8'hff, i == n - 1, rd[i], ack);
      M.stop();
   endtask
   task automatic pulse(input logic rom);
      @(posedge ref_clk);
      #1 {rom_done, host_load} = {rom, !rom};
      @(posedge ref_clk);
      #1 {rom_done, host_load} = 2'b00;
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1 rd_regs(8'h04, 4);
      `CHK("reset out", 32'h00000000, {rd[3], rd[2], rd[1], rd[0]})
      M.start();
      M.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, junk, ack);
      M.xfer(8'h00, 1'b1, junk, ack);
      `CHK("foreign ack", 1'b0, ack)
      M.stop();
      sends = 0;
      wr(8'h00, '{8'h3f, 8'h11, 8'h22, 8'h33}, 4);
      `CHK("sends", 4, sends)
      `CHK("report", 32'h33221135, rpt)
      rd_regs(8'h00, 4);
      `CHK("in bytes", 32'h33221135, {rd[3], rd[2], rd[1], rd[0]})
      sends = 0;
      btn = 4'ha;
      repeat (20) @(posedge ref_clk);
      #1 `CHK("button send", 1, sends)
      `CHK("button report", 32'h3322113a, rpt)
      host_data = 32'h44332211;
      pulse(1'b0);
      `CHK("irq load", 1'b1, irq)
      rd_regs(8'h04, 4);
      `CHK("out bytes", 32'h44332211, {rd[3], rd[2], rd[1], rd[0]})
      `CHK("irq clear", 1'b0, irq)
      wr(8'h00, '{8'ha0, 8'h66, 8'h77, 8'h05}, 4);
      `CHK("clock code", 2'h2, clk_code)
      `CHK("rom word", 16'h7766, rom_wdata)
      `CHK("rom addr", 6'h05, rom_addr)
      rd_regs(8'h05, 3);
      `CHK("mapped", 24'h057766, {rd[2], rd[1], rd[0]})
      starts = 0;
      wr(8'h0b, '{8'h45, 8'h00, 8'h00, 8'h00}, 1);
      `CHK("no start", 0, starts)
      `CHK("rom dir", 1'b1, rom_write)
      wr(8'h0b, '{8'h89, 8'h00, 8'h00, 8'h00}, 1);
      `CHK("one start", 1, starts)
      rd_regs(8'h0b, 1);
      `CHK("pending", 8'h89, rd[0])
      rom_rdata = 16'hbeef;
      pulse(1'b1);
      `CHK("irq rom", 1'b1, irq)
      rd_regs(8'h09, 3);
      `CHK("rom read", 24'h09beef, {rd[2], rd[1], rd[0]})
      rd_regs(8'h04, 4);
      `CHK("mapped rom", 24'h09beef, {rd[3], rd[2], rd[1]})
      `CHK("irq rom clear", 1'b0, irq)
      final_report();
   end
   // Watchdog well beyond the expected run time.
   initial
   begin
      #400us;
      fail_count++;
      final_report();
   end
endmodule
